// >>> design/mcsc_top.sv
// Purpose: Main clock source control: sources, trims, write protection
// Assumes: Source tick inputs are one-cycle pulses, one per source edge
// Notes:   Avalon-MM slave, one wait cycle on every access
//
// Contract
// [R1] Fast oscillator centers at 16 or 20 MHz per fuse field.
// [R2] After reset the fuse frequency sets the main clock frequency.
// [R3] Both fast oscillator trims load from fuse values at reset.
// [R4] Six-bit frequency trim and four-bit temperature slope trim exist.
// [R5] Trim lock fuse set blocks every software trim change.
// [R6] Main clock lock plus fast oscillator as main blocks trim changes.
// [R7] Fast oscillator output only after analog start plus 4 cycles.
// [R8] Software should slow the main clock before retrimming it.
// [R9] Low-power oscillator output after analog start plus 4 cycles.
// [R10] Low-power oscillator produces a 1 kHz tick for timers.
// [R11] Crystal or external 32 kHz clock, chosen by source select.
// [R12] Crystal runs only when enabled; enable overrides its two pins.
// [R13] Two-bit field selects crystal startup wait.
// [R14] External clock on first crystal pin starts in 2 cycles.
// [R15] Crystal oscillator has no trim.
// [R16] External clock request configures the external clock pin.
// [R17] External clock input starts in 2 cycles on first request.
// [R18] Software writes key, then protected write within four instructions.
// [R19] Protected writes outside the window are accepted but ignored.
// [R20] Eight registers are protected by the same key.
// [R21] Select control resets 0x00: output enable bit 7, source bits 1:0.
// [R22] Window counter loads on key, closes after 4 instructions or a write.
// [R23] Source choice 0 fast, 1 low-power, 2 crystal, 3 external.
// [R24] Output enable set drives system clock onto the output pin.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module mcsc_top (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          sys_rst,
	// Avalon-MM slave
	input  wire logic [7:0]                    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic      [31:0]                   avs_readdata,
	output logic                               avs_waitrequest,
	// Oscillator configuration fuse and factory trims
	input  wire logic [1:0]                    center_freq_fuse_field,
	input  wire logic                          trim_lock_fuse_bit,
	input  wire logic [5:0]                    fuse_freq_trim,
	input  wire logic [3:0]                    fuse_temp_trim,
	// CPU instruction retire pulse
	input  wire logic                          cpu_instr_done,
	// Peripheral requests per source, index is the source choice
	input  wire logic [3:0]                    periph_req,
	// Analog start done per source, index as above
	input  wire logic [3:0]                    analog_ok,
	// One pulse per source edge, index as above
	input  wire logic [3:0]                    src_tick,
	// Oscillator controls
	output logic      [3:0]                    src_run,
	output logic      [3:0]                    src_gate_open,
	output logic                               fast_osc_20mhz,
	output logic      [5:0]                    fast_osc_freq_trim_field,
	output logic      [3:0]                    fast_osc_temp_slope_field,
	output logic                               crystal_ext_clock_mode,
	// Pin overrides
	output logic                               crystal_pins_override,
	output logic                               external_clock_pin_override,
	output logic                               system_clock_output_en,
	// Main clock
	output logic      [1:0]                    main_source_choice,
	output logic      [4:0]                    main_prescale,
	output logic                               tick_1khz
);
	import mcsc_pkg::*;
	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  sel_ctrl_ff,   nxt_sel_ctrl;
	logic [4:0]  presc_ff,      nxt_presc;
	logic        lock_en_ff,    nxt_lock_en;
	logic        fast_stby_ff,  nxt_fast_stby;
	logic        lp_stby_ff,    nxt_lp_stby;
	logic [5:0]  xtal_ff,       nxt_xtal;
	logic [5:0]  ftrim_ff,      nxt_ftrim;
	logic [3:0]  ttrim_ff,      nxt_ttrim;
	logic        tlock_ff;
	logic        freq20_ff;
	logic        fuse_load_ff;
	logic [2:0]  win_ff,        nxt_win;
	logic [1:0]  active_ff,     nxt_active;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic [4:0]  khz_cnt_ff;
	logic        khz_ff;
	logic [3:0]  run_ff, gate_ff, req_seen_ff;
	logic        xpin_ff, epin_ff, cko_ff;
	////////////////////////////////////////////////////////////////////
	// Bus decode
	wire [5:0] idx      = avs_address[7:2];
	wire       aligned  = (avs_address[1:0] == 2'h0);
	wire       wr_fire  = avs_write & ~wait_ff & avs_byteenable[0];
	wire [7:0] wbyte    = avs_writedata[7:0];
	wire hit_sel   = aligned & (idx == IDX_SEL_CTRL);
	wire hit_presc = aligned & (idx == IDX_PRESC_CTRL);
	wire hit_lock  = aligned & (idx == IDX_LOCK);
	wire hit_state = aligned & (idx == IDX_STATE);
	wire hit_fast  = aligned & (idx == IDX_FAST_CTRL);
	wire hit_ftrim = aligned & (idx == IDX_FREQ_TRIM);
	wire hit_ttrim = aligned & (idx == IDX_TEMP_TRIM);
	wire hit_lp    = aligned & (idx == IDX_LP_CTRL);
	wire hit_xtal  = aligned & (idx == IDX_XTAL_CTRL);
	wire hit_key   = aligned & (idx == IDX_UNLOCK);
	////////////////////////////////////////////////////////////////////
	// Write protection
	wire window_open = (win_ff != 3'h0);
	// [R20] same key guards eight registers
	wire hit_prot = hit_sel | hit_presc | hit_lock | hit_fast
		| hit_ftrim | hit_ttrim | hit_lp | hit_xtal;
	// [R19] closed window drops the write
	wire prot_wr  = wr_fire & hit_prot & window_open;
	wire key_wr   = wr_fire & hit_key & (wbyte == UNLOCK_KEY);
	// Main lock freezes selection, prescaler and itself until reset
	wire main_wr_ok = prot_wr & ~lock_en_ff;
	// [R5] fuse lock, [R6] main lock on fast source
	wire trim_wr_ok = prot_wr & ~tlock_ff
		& ~(lock_en_ff & (active_ff == SRC_FAST));

	// [R22] four-instruction window, closed by any protected write
	assign nxt_win = key_wr ? WINDOW_INSTR : (prot_wr ? 3'h0 :
		((cpu_instr_done & window_open) ? win_ff - 3'h1 : win_ff));
	////////////////////////////////////////////////////////////////////
	// Register next values
	// [R21] only output enable and source bits are kept
	assign nxt_sel_ctrl = (main_wr_ok & hit_sel) ?
		(wbyte & 8'h83) : sel_ctrl_ff;
	assign nxt_presc    = (main_wr_ok & hit_presc) ? wbyte[4:0] : presc_ff;
	assign nxt_lock_en  = lock_en_ff | (main_wr_ok & hit_lock & wbyte[0]);
	assign nxt_fast_stby = (prot_wr & hit_fast) ?
		wbyte[RUNSTBY_BIT] : fast_stby_ff;
	assign nxt_lp_stby  = (prot_wr & hit_lp) ?
		wbyte[RUNSTBY_BIT] : lp_stby_ff;
	// [R15] crystal control holds no trim bits
	assign nxt_xtal     = (prot_wr & hit_xtal) ? wbyte[5:0] : xtal_ff;
	// [R4] six-bit and four-bit trim fields
	assign nxt_ftrim    = (trim_wr_ok & hit_ftrim) ? wbyte[5:0] : ftrim_ff;
	assign nxt_ttrim    = (trim_wr_ok & hit_ttrim) ? wbyte[3:0] : ttrim_ff;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sel_ctrl_ff  <= SEL_CTRL_RST;
			presc_ff     <= PRESC_CTRL_RST;
			lock_en_ff   <= 1'b0;
			fast_stby_ff <= 1'b0;
			lp_stby_ff   <= 1'b0;
			xtal_ff      <= 6'h00;
			win_ff       <= 3'h0;
		end else begin
			sel_ctrl_ff  <= nxt_sel_ctrl;
			presc_ff     <= nxt_presc;
			lock_en_ff   <= nxt_lock_en;
			fast_stby_ff <= nxt_fast_stby;
			lp_stby_ff   <= nxt_lp_stby;
			xtal_ff      <= nxt_xtal;
			win_ff       <= nxt_win;
		end
	end
	// [R3] fuse trims caught on the first edge after release
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fuse_load_ff <= 1'b1;
			ftrim_ff     <= 6'h00;
			ttrim_ff     <= 4'h0;
			tlock_ff     <= 1'b1;
			freq20_ff    <= 1'b0;
		end else if (fuse_load_ff) begin
			fuse_load_ff <= 1'b0;
			ftrim_ff     <= fuse_freq_trim;
			ttrim_ff     <= fuse_temp_trim;
			tlock_ff     <= trim_lock_fuse_bit;
			// [R1] [R2] fuse picks the center frequency
			freq20_ff    <= (center_freq_fuse_field == FREQ_20MHZ);
		end else begin
			ftrim_ff     <= nxt_ftrim;
			ttrim_ff     <= nxt_ttrim;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Source startup
	wire [1:0] xsu  = xtal_ff[XSTART_LO+1:XSTART_LO];
	wire       xsel = xtal_ff[XSEL_BIT];
	wire       xen  = xtal_ff[XENABLE_BIT];
	// [R11] select bit picks mode, [R13] [R14] start wait
	wire [12:0] xtal_need = xsel ? EXT_START_CYC :
		(xsu == 2'h0) ? XSTART_CYC_0 : (xsu == 2'h1) ? XSTART_CYC_1 :
		(xsu == 2'h2) ? XSTART_CYC_2 : XSTART_CYC_3;
	wire [1:0] want_src = sel_ctrl_ff[1:0];
	wire [3:0] stby = {1'b0, xtal_ff[RUNSTBY_BIT], lp_stby_ff,
		fast_stby_ff};
	// Crystal and external clock need no analog settle input
	wire [3:0] settle = {1'b1, 1'b1, analog_ok[1:0]};
	wire [3:0] src_req, src_used;
	logic [12:0] need [4];
	logic [12:0] cnt_ff [4];
	// [R7] [R9] RC sources count 4 cycles after analog start
	assign need[0] = RC_GATE_CYCLES;
	assign need[1] = RC_GATE_CYCLES;
	assign need[2] = xtal_need;
	// [R17] external clock input starts in 2 cycles
	assign need[3] = EXT_START_CYC;
	// [R23] source index equals the main source choice code
	generate
		for (genvar g = 0; g < 4; g++) begin : g_src
			assign src_used[g] = periph_req[g]
				| (want_src == 2'(g)) | (active_ff == 2'(g));
			// [R12] crystal starts only while enabled
			assign src_req[g] = (src_used[g] | stby[g])
				& ((g != 2) | xen);
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_ff[g]  <= 13'h0000;
					gate_ff[g] <= 1'b0;
				end else if (!src_req[g]) begin
					cnt_ff[g]  <= 13'h0000;
					gate_ff[g] <= 1'b0;
				end else if (!gate_ff[g] && settle[g] && src_tick[g]) begin
					cnt_ff[g]  <= cnt_ff[g] + 13'h0001;
					gate_ff[g] <= (cnt_ff[g] + 13'h0001 >= need[g]);
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// Main source switch waits for the new source to be stable
	assign nxt_active = (want_src != active_ff) && gate_ff[want_src] ?
		want_src : active_ff;
	wire sosc = (want_src != active_ff);
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			active_ff   <= SRC_FAST;
			run_ff      <= 4'h0;
			req_seen_ff <= 4'h0;
			xpin_ff     <= 1'b0;
			epin_ff     <= 1'b0;
			cko_ff      <= 1'b0;
		end else begin
			active_ff   <= nxt_active;
			run_ff      <= src_req;
			req_seen_ff <= src_used;
			// [R12] enabled crystal owns both of its pins
			xpin_ff     <= xen;
			// [R16] any request claims the external clock pin
			epin_ff     <= src_req[SRC_EXT];
			// [R24] clock output pin enable
			cko_ff      <= sel_ctrl_ff[CKOUT_BIT];
		end
	end
	////////////////////////////////////////////////////////////////////
	// [R10] 1 kHz tick from the low-power source
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			khz_cnt_ff <= 5'h00;
			khz_ff     <= 1'b0;
		end else begin
			khz_ff <= 1'b0;
			if (gate_ff[SRC_LP] && src_tick[SRC_LP]) begin
				khz_cnt_ff <= khz_cnt_ff + 5'h01;
				khz_ff     <= (khz_cnt_ff == KHZ_DIV_LAST);
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Read mux and wait state
	// Status shows stable only while the source is actually used
	wire [3:0] sts = gate_ff & req_seen_ff;
	wire [7:0] rd_state = {sts[SRC_EXT], sts[SRC_XTAL], sts[SRC_LP],
		sts[SRC_FAST], 3'h0, sosc};
	wire [7:0] rd_byte =
		hit_sel   ? sel_ctrl_ff :
		hit_presc ? {3'h0, presc_ff} :
		hit_lock  ? {7'h00, lock_en_ff} :
		hit_state ? rd_state :
		hit_fast  ? {6'h00, fast_stby_ff, 1'b0} :
		hit_ftrim ? {2'h0, ftrim_ff} :
		hit_ttrim ? {tlock_ff, 3'h0, ttrim_ff} :
		hit_lp    ? {6'h00, lp_stby_ff, 1'b0} :
		hit_xtal  ? {2'h0, xtal_ff} :
		hit_key   ? {7'h00, window_open} : 8'h00;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else begin
			// One wait cycle keeps the answer on a flop
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
			if (avs_read && wait_ff)
				rdata_ff <= {24'h000000, rd_byte};
		end
	end
	////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_readdata                = rdata_ff;
	assign avs_waitrequest             = wait_ff;
	assign src_run                     = run_ff;
	assign src_gate_open               = gate_ff;
	assign fast_osc_20mhz              = freq20_ff;
	assign fast_osc_freq_trim_field    = ftrim_ff;
	assign fast_osc_temp_slope_field   = ttrim_ff;
	assign crystal_ext_clock_mode      = xtal_ff[XSEL_BIT];
	assign crystal_pins_override       = xpin_ff;
	assign external_clock_pin_override = epin_ff;
	assign system_clock_output_en      = cko_ff;
	assign main_source_choice          = active_ff;
	assign main_prescale               = presc_ff;
	assign tick_1khz                   = khz_ff;
	////////////////////////////////////////////////////////////////////
	// Checks
	property p_wait_one;
		@(posedge clock) disable iff (sys_rst)
		(avs_read | avs_write) && wait_ff |=> !wait_ff ##1 wait_ff;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state bad");
	property p_key_open; // [R22]
		@(posedge clock) disable iff (sys_rst)
		key_wr |=> win_ff == 3'h4;
	endproperty
	a_key_open: assert property (p_key_open) else $error("key no window");
	property p_win_close; // [R22]
		@(posedge clock) disable iff (sys_rst)
		prot_wr && !key_wr |=> !window_open;
	endproperty
	a_win_close: assert property (p_win_close) else $error("window open");
	property p_closed_ignored; // [R19]
		@(posedge clock) disable iff (sys_rst)
		wr_fire && hit_sel && !window_open |=> $stable(sel_ctrl_ff);
	endproperty
	a_closed_ignored: assert property (p_closed_ignored)
		else $error("write passed closed window");
	property p_fuse_lock; // [R5]
		@(posedge clock) disable iff (sys_rst)
		!fuse_load_ff && tlock_ff |=> $stable(ftrim_ff) && $stable(ttrim_ff);
	endproperty
	a_fuse_lock: assert property (p_fuse_lock) else $error("trim changed");
	property p_main_lock; // [R6]
		@(posedge clock) disable iff (sys_rst)
		!fuse_load_ff && lock_en_ff && active_ff == SRC_FAST
		&& $stable(active_ff) |=> $stable(ftrim_ff);
	endproperty
	a_main_lock: assert property (p_main_lock) else $error("main lock");
	property p_rc_start; // [R7]
		@(posedge clock) disable iff (sys_rst)
		$rose(gate_ff[0]) |-> $past(cnt_ff[0]) == 13'h0003;
	endproperty
	a_rc_start: assert property (p_rc_start) else $error("fast start");
	property p_xtal_enable; // [R12]
		@(posedge clock) disable iff (sys_rst)
		gate_ff[SRC_XTAL] |-> $past(xen);
	endproperty
	a_xtal_enable: assert property (p_xtal_enable) else $error("xtal off");
	property p_ext_pin; // [R16]
		@(posedge clock) disable iff (sys_rst)
		periph_req[SRC_EXT] |=> epin_ff;
	endproperty
	a_ext_pin: assert property (p_ext_pin) else $error("pin not claimed");
	property p_system_clock_output; // [R24]
		@(posedge clock) disable iff (sys_rst)
		sel_ctrl_ff[CKOUT_BIT] |=> cko_ff;
	endproperty
	a_system_clock_output: assert property (p_system_clock_output) else $error("clock out off");
	c_unlock_write: cover property (@(posedge clock) key_wr ##[1:8] prot_wr);
	c_switch: cover property (@(posedge clock) $changed(active_ff));
	c_khz: cover property (@(posedge clock) khz_ff);
endmodule : mcsc_top

// >>> design/mcsc_pkg.sv
// Purpose: Shared constants for the main clock source control block
// Assumes: Avalon-MM byte addresses are four times the register index
// Notes:   Startup counts are in cycles of the source being started
package mcsc_pkg;
	// Register indices; byte address is index times four
	localparam logic [5:0] IDX_SEL_CTRL   = 6'h00;
	localparam logic [5:0] IDX_PRESC_CTRL = 6'h01;
	localparam logic [5:0] IDX_LOCK       = 6'h02;
	localparam logic [5:0] IDX_STATE      = 6'h03;
	localparam logic [5:0] IDX_FAST_CTRL  = 6'h10;
	localparam logic [5:0] IDX_FREQ_TRIM  = 6'h11;
	localparam logic [5:0] IDX_TEMP_TRIM  = 6'h12;
	localparam logic [5:0] IDX_LP_CTRL    = 6'h18;
	localparam logic [5:0] IDX_XTAL_CTRL  = 6'h1C;
	localparam logic [5:0] IDX_UNLOCK     = 6'h20;
	// Field positions
	localparam int CKOUT_BIT    = 7;
	localparam int RUNSTBY_BIT  = 1;
	localparam int XENABLE_BIT  = 0;
	localparam int XSEL_BIT     = 2;
	localparam int XSTART_LO    = 4;
	localparam int TRIMLOCK_BIT = 7;
	localparam int EXTS_BIT     = 7;
	localparam int SOSC_BIT     = 0;
	localparam int FAST_STS_BIT = 4;
	// Reset values
	localparam logic [7:0] SEL_CTRL_RST   = 8'h00;
	localparam logic [4:0] PRESC_CTRL_RST = 5'h11;
	// Unlock key value, arbitrary
	localparam logic [7:0] UNLOCK_KEY     = 8'hA5;
	localparam logic [2:0] WINDOW_INSTR   = 3'h4;
	// Source indices, also the main source choice encoding
	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_LP   = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [1:0] SRC_EXT  = 2'h3;
	// Startup counts in source cycles
	localparam logic [12:0] RC_GATE_CYCLES  = 13'h0004;
	localparam logic [12:0] EXT_START_CYC   = 13'h0002;
	localparam logic [12:0] XSTART_CYC_0    = 13'h0100;
	localparam logic [12:0] XSTART_CYC_1    = 13'h0400;
	localparam logic [12:0] XSTART_CYC_2    = 13'h0800;
	localparam logic [12:0] XSTART_CYC_3    = 13'h1000;
	// Last count of the 32 low-power source cycles per 1 kHz tick
	localparam logic [4:0]  KHZ_DIV_LAST    = 5'h1F;
	// Center frequency fuse codes
	localparam logic [1:0]  FREQ_16MHZ      = 2'h1;
	localparam logic [1:0]  FREQ_20MHZ      = 2'h2;
endpackage : mcsc_pkg

// >>> testbench/mcsc_top_tb.sv
// Purpose: Self-checking bench for the main clock source control block
// Assumes: One wait cycle per bus access, byte registers in lane 0
// Notes:   Source ticks are pulsed by the bench, two clocks apart
`timescale 1ns/1ps
module mcsc_top_tb;
	import mcsc_pkg::*;
	logic        clock          = 1'b0;
	logic        sys_rst        = 1'b1;
	logic [7:0]  avs_address    = 8'h00;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [1:0]  center_freq_fuse_field = FREQ_20MHZ;
	logic        trim_lock_fuse_bit     = 1'b0;
	logic [5:0]  fuse_freq_trim         = 6'h2A;
	logic [3:0]  fuse_temp_trim         = 4'h5;
	logic        cpu_instr_done = 1'b0;
	logic [3:0]  periph_req     = 4'h0;
	logic [3:0]  analog_ok      = 4'h0;
	logic [3:0]  src_tick       = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  src_run;
	logic [3:0]  src_gate_open;
	logic        fast_osc_20mhz;
	logic [5:0]  fast_osc_freq_trim_field;
	logic [3:0]  fast_osc_temp_slope_field;
	logic        crystal_ext_clock_mode;
	logic        crystal_pins_override;
	logic        external_clock_pin_override;
	logic        system_clock_output_en;
	logic [1:0]  main_source_choice;
	logic [4:0]  main_prescale;
	logic        tick_1khz;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          cycles     = 0;
	int          khz_n      = 0;
	int          khz_base   = 0;
	logic [7:0]  q;

	mcsc_top uut (.clock, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.center_freq_fuse_field, .trim_lock_fuse_bit, .fuse_freq_trim,
		.fuse_temp_trim, .cpu_instr_done, .periph_req, .analog_ok,
		.src_tick, .src_run, .src_gate_open, .fast_osc_20mhz,
		.fast_osc_freq_trim_field, .fast_osc_temp_slope_field,
		.crystal_ext_clock_mode, .crystal_pins_override,
		.external_clock_pin_override, .system_clock_output_en,
		.main_source_choice, .main_prescale, .tick_1khz);

	always #10 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// Hang guard, well above the roughly one thousand cycles the run needs
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (tick_1khz === 1'b1)
			khz_n <= khz_n + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////
	// Bus cycle: hold until waitrequest is sampled low, then release
	task automatic bus(input logic wr, input logic [5:0] idx,
		input logic [7:0] d);
		@(posedge clock);
		avs_address   <= {idx, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task automatic rdc(input string nm, input logic [5:0] idx,
		input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, {24'h0, q});
	endtask : rdc

	// Key first, then the protected write right behind it
	task automatic pw(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, IDX_UNLOCK, UNLOCK_KEY);
		bus(1'b1, idx, d);
	endtask : pw

	task automatic instr(input int n);
		repeat (n) begin
			@(posedge clock) cpu_instr_done <= 1'b1;
			@(posedge clock) cpu_instr_done <= 1'b0;
		end
	endtask : instr

	task automatic tick(input int i, input int n);
		repeat (n) begin
			@(posedge clock) src_tick[i] <= 1'b1;
			@(posedge clock) src_tick[i] <= 1'b0;
		end
		repeat (3) @(posedge clock);
	endtask : tick

	// Gate must stay shut one tick short of the count, then open
	task automatic src_check(input int i, input int need);
		@(posedge clock) periph_req[i] <= 1'b1;
		tick(i, need - 1);
		chk("gate early", 32'h0, {31'h0, src_gate_open[i]});
		tick(i, 1);
		chk("gate open", 32'h1, {31'h0, src_gate_open[i]});
		@(posedge clock) periph_req[i] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : src_check

	task automatic do_reset(input logic [1:0] fsel, input logic lk);
		@(posedge clock);
		sys_rst                <= 1'b1;
		center_freq_fuse_field <= fsel;
		trim_lock_fuse_bit     <= lk;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(FREQ_20MHZ, 1'b0);
		analog_ok <= 4'h3;
		rdc("select", IDX_SEL_CTRL, SEL_CTRL_RST);
		rdc("prescale", IDX_PRESC_CTRL, {3'h0, PRESC_CTRL_RST});
		chk("20mhz", 32'h1, {31'h0, fast_osc_20mhz});
		rdc("freq trim", IDX_FREQ_TRIM, 8'h2A);
		rdc("temp trim", IDX_TEMP_TRIM, 8'h05);
		chk("temp port", 32'h5, {28'h0, fast_osc_temp_slope_field});
		// Unkeyed and unmapped accesses
		bus(1'b1, IDX_SEL_CTRL, 8'h80);
		rdc("select unkeyed", IDX_SEL_CTRL, 8'h00);
		rdc("unmapped", 6'h04, 8'h00);
		pw(IDX_SEL_CTRL, 8'hFC);
		rdc("select keyed", IDX_SEL_CTRL, 8'h80);
		repeat (2) @(posedge clock);
		chk("system_clock_output", 32'h1, {31'h0, system_clock_output_en});
		chk("prescale port", {27'h0, PRESC_CTRL_RST}, {27'h0, main_prescale});
		// Window: three instructions still open, four closed
		bus(1'b1, IDX_UNLOCK, UNLOCK_KEY);
		instr(3);
		bus(1'b1, IDX_FREQ_TRIM, 8'h15);
		rdc("trim in window", IDX_FREQ_TRIM, 8'h15);
		chk("trim port", 32'h15, {26'h0, fast_osc_freq_trim_field});
		bus(1'b1, IDX_FREQ_TRIM, 8'h00);
		rdc("second write", IDX_FREQ_TRIM, 8'h15);
		bus(1'b1, IDX_UNLOCK, UNLOCK_KEY);
		instr(4);
		bus(1'b1, IDX_FREQ_TRIM, 8'h00);
		rdc("window shut", IDX_FREQ_TRIM, 8'h15);
		// Source start-up counts
		@(posedge clock) periph_req[3] <= 1'b1;
		repeat (3) @(posedge clock);
		chk("ext pin", 32'h1, {31'h0, external_clock_pin_override});
		chk("ext run", 32'h1, {31'h0, src_run[3]});
		@(posedge clock) periph_req[3] <= 1'b0;
		repeat (3) @(posedge clock);
		src_check(3, 2);
		src_check(0, 4);
		src_check(1, 4);
		// Crystal stays off while disabled
		@(posedge clock) periph_req[2] <= 1'b1;
		tick(2, 4);
		chk("xtal off", 32'h0, {31'h0, src_gate_open[2]});
		chk("xtal run", 32'h0, {31'h0, src_run[2]});
		@(posedge clock) periph_req[2] <= 1'b0;
		pw(IDX_XTAL_CTRL, 8'h01);
		repeat (2) @(posedge clock);
		chk("xtal pins", 32'h1, {31'h0, crystal_pins_override});
		src_check(2, 256);
		pw(IDX_XTAL_CTRL, 8'h05);
		rdc("xtal ctrl", IDX_XTAL_CTRL, 8'h05);
		chk("xtal ext", 32'h1, {31'h0, crystal_ext_clock_mode});
		src_check(2, 2);
		// Two kilohertz ticks per 64 low-power edges
		@(posedge clock) periph_req[1] <= 1'b1;
		tick(1, 4);
		khz_base = khz_n;
		tick(1, 64);
		chk("khz ticks", 32'h2, khz_n - khz_base);
		@(posedge clock) periph_req[1] <= 1'b0;
		// Main source switch and back
		pw(IDX_SEL_CTRL, 8'h81);
		tick(1, 4);
		chk("main lp", {30'h0, SRC_LP}, {30'h0, main_source_choice});
		pw(IDX_SEL_CTRL, 8'h80);
		tick(0, 4);
		chk("main fast", {30'h0, SRC_FAST}, {30'h0, main_source_choice});
		// Lock blocks trims of the active fast source
		pw(IDX_LOCK, 8'h01);
		rdc("lock", IDX_LOCK, 8'h01);
		pw(IDX_FREQ_TRIM, 8'h01);
		rdc("locked trim", IDX_FREQ_TRIM, 8'h15);
		pw(IDX_SEL_CTRL, 8'h00);
		rdc("locked select", IDX_SEL_CTRL, 8'h80);
		// Fuse lock and 16 MHz center after a fresh reset
		do_reset(FREQ_16MHZ, 1'b1);
		chk("16mhz", 32'h0, {31'h0, fast_osc_20mhz});
		rdc("lock bit", IDX_TEMP_TRIM, 8'h85);
		pw(IDX_TEMP_TRIM, 8'h0A);
		rdc("fuse locked", IDX_TEMP_TRIM, 8'h85);
		pw(IDX_FREQ_TRIM, 8'h01);
		rdc("fuse locked freq", IDX_FREQ_TRIM, 8'h2A);
		end_of_test();
	end
endmodule : mcsc_top_tb
